// File: logic/current_dac_serial_port.sv
// serial input port, load strobe, clear and alert of a current converter
// assumes host sends whole 24-bit frames and holds sclk still while the
// load strobe is high; clk_sys is free running at 200 MHz
`timescale 1ns/10ps
`default_nettype none
module current_dac_serial_port (
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic sclk, // serial clock from host
  input wire logic serial_in, // serial data from host
  input wire logic latchPin, // load strobe, rising edge acts
  input wire logic clearPin, // clear, active high
  input wire logic openLoopPin, // open circuit detector level
  input wire logic overTempPin, // overtemperature detector level
  output logic serial_out, // serial data to host
  output logic serialOutEn, // high while serial_out is driven
  output logic faultOut, // alert pin value, always low
  output logic faultOe, // alert pull-down enable
  output logic [15:0] current_output, // code steering the output current
  output logic [1:0] outRange // selected current range
);
  // ---------------- link side, sclk domain ----------------
  logic rstLink;
  logic [dac_port_pkg::FRAME_BITS-1:0] shiftReg;
  logic [dac_port_pkg::CNT_BITS-1:0] bitCnt;
  logic [dac_port_pkg::CNT_BITS-1:0] next_bitCnt;
  logic outBit;
  logic shiftLsb;

  // link reset taken onto sclk; host must clock twice while rst is high
  bit_sync u_rst_link (
    .clk(sclk),
    .rst(1'b0),
    .din(rst),
    .dout(rstLink)
  );

  // bit count within the frame, wraps at frame length
  assign next_bitCnt = (bitCnt == 5'(dac_port_pkg::FRAME_BITS - 1)) ?
                       dac_port_pkg::CNT_RESET : bitCnt + 5'h01;
  assign shiftLsb = shiftReg[0];

  // input shift on rising edges, rated to the host clock ceiling
  always_ff @(posedge sclk) begin
    if (rstLink) begin
      shiftReg <= '0;
      bitCnt <= dac_port_pkg::CNT_RESET;
    end else begin
      shiftReg <= {shiftReg[dac_port_pkg::FRAME_BITS-2:0], serial_in};
      bitCnt <= next_bitCnt;
    end
  end

  // ---------------- system side, clk_sys domain ----------------
  logic latchSync;
  logic latchLast;
  logic clearSync;
  logic openSync;
  logic overSync;
  dac_port_pkg::fault_s faultSync;
  typedef dac_port_pkg::out_mode_e out_mode_local_t;
  out_mode_local_t outMode;
  logic [15:0] dataReg;
  logic [15:0] ctrlReg;
  logic [dac_port_pkg::FRAME_BITS-1:0] readWord;

  bit_sync u_latch (.clk(clk_sys), .rst(rst), .din(latchPin), .dout(latchSync));
  bit_sync u_clear (.clk(clk_sys), .rst(rst), .din(clearPin), .dout(clearSync));
  bit_sync u_open (.clk(clk_sys), .rst(rst), .din(openLoopPin), .dout(openSync));
  bit_sync u_temp (.clk(clk_sys), .rst(rst), .din(overTempPin), .dout(overSync));

  // one driver for the whole struct; open loop is the upper member
  assign faultSync = {openSync, overSync};

  // the frame is quiet while the strobe is high, so the strobe acts as the
  // request of a handshake and the word is sampled only after it is seen
  dac_port_pkg::link_word_s word;
  logic latchRise;
  logic isData;
  logic isCtrl;
  logic isRead;
  logic daisyEn;
  logic [15:0] next_dataReg;
  logic [15:0] next_ctrlReg;
  logic [15:0] readValue;
  logic [15:0] next_code;

  assign word = shiftReg;
  assign latchRise = latchSync & ~latchLast;
  assign isData = latchRise && (word.addr == dac_port_pkg::ADDR_DATA);
  assign isCtrl = latchRise && (word.addr == dac_port_pkg::ADDR_CTRL);
  assign isRead = latchRise && (word.addr == dac_port_pkg::ADDR_READ);
  assign next_dataReg = isData ? word.data : dataReg;
  assign next_ctrlReg = isCtrl ? word.data : ctrlReg;
  assign daisyEn = next_ctrlReg[dac_port_pkg::CTRL_DAISY_BIT];
  // zero scale is code zero in every range; the range sets 0 or 4 mA
  assign next_code = clearSync ? dac_port_pkg::ZERO_SCALE_CODE : next_dataReg;

  // readback selector; unknown selectors read as zero
  assign readValue =
    (word.data[1:0] == dac_port_pkg::SEL_STATUS) ?
      {13'h0000, clearSync, faultSync.overTemp, faultSync.openLoop} :
    (word.data[1:0] == dac_port_pkg::SEL_DATA) ? dataReg :
    (word.data[1:0] == dac_port_pkg::SEL_CTRL) ? ctrlReg : 16'h0000;

  // registers, output code and strobe edge detector
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latchLast <= 1'b0;
      dataReg <= dac_port_pkg::DATA_RESET;
      ctrlReg <= dac_port_pkg::CTRL_RESET;
      current_output <= dac_port_pkg::ZERO_SCALE_CODE;
      readWord <= '0;
    end else begin
      latchLast <= latchSync;
      dataReg <= next_dataReg;
      ctrlReg <= next_ctrlReg;
      current_output <= next_code;
      if (isRead) begin
        readWord <= {word.addr, readValue};
      end
    end
  end

  assign outRange = ctrlReg[dac_port_pkg::CTRL_RANGE_LSB+:2];

  // output mode: readback lasts one frame, ended by the next strobe rise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      outMode <= dac_port_pkg::OUT_OFF;
    end else if (latchRise) begin
      case (1'b1)
        isRead: outMode <= dac_port_pkg::OUT_READ;
        daisyEn: outMode <= dac_port_pkg::OUT_DAISY;
        default: outMode <= dac_port_pkg::OUT_OFF;
      endcase
    end
  end

  assign serialOutEn = (outMode != dac_port_pkg::OUT_OFF);

  // serial output bit, updated on falling edges; mode and readWord are
  // quiet long before the frame begins, held by the strobe handshake
  always_ff @(negedge sclk) begin
    if (rstLink) begin
      outBit <= 1'b0;
    end else if (outMode == dac_port_pkg::OUT_READ) begin
      outBit <= readWord[5'(dac_port_pkg::FRAME_BITS - 1) - bitCnt];
    end else begin
      outBit <= shiftReg[dac_port_pkg::FRAME_BITS-1];
    end
  end

  // first readback bit must stand before the first rising edge
  assign serial_out = (outMode == dac_port_pkg::OUT_READ && bitCnt == dac_port_pkg::CNT_RESET) ?
                      readWord[dac_port_pkg::FRAME_BITS-1] : outBit;

  // alert follows the detectors as a plain level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      faultOe <= 1'b0;
    end else begin
      faultOe <= faultSync.openLoop | faultSync.overTemp;
    end
  end

  assign faultOut = 1'b0;

  // ---------------- checks ----------------
  property p_shift_in;
    @(posedge sclk) disable iff (rstLink)
    !$past(rstLink) |-> shiftLsb == $past(serial_in);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial input bit not shifted");

  property p_load_data;
    @(posedge clk_sys) disable iff (rst)
    isData |=> dataReg == $past(word.data);
  endproperty
  a_load_data: assert property (p_load_data) else $error("data word not loaded");

  property p_code_update;
    @(posedge clk_sys) disable iff (rst)
    (isData && !clearSync) |=> current_output == $past(word.data);
  endproperty
  a_code_update: assert property (p_code_update) else $error("output code not updated");

  property p_clear_zero;
    @(posedge clk_sys) disable iff (rst)
    clearSync |=> current_output == dac_port_pkg::ZERO_SCALE_CODE;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not force zero");

  property p_hold_data;
    @(posedge clk_sys) disable iff (rst)
    !latchRise |=> $stable(dataReg) && $stable(ctrlReg);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("register changed without strobe");

  property p_out_modes;
    @(posedge clk_sys) disable iff (rst)
    serialOutEn |-> (outMode == dac_port_pkg::OUT_READ) || ctrlReg[dac_port_pkg::CTRL_DAISY_BIT];
  endproperty
  a_out_modes: assert property (p_out_modes) else $error("serial output driven outside modes");

  property p_read_release;
    @(posedge clk_sys) disable iff (rst)
    (latchRise && !isRead && !daisyEn) |=> !serialOutEn;
  endproperty
  a_read_release: assert property (p_read_release) else $error("serial output not released");

  property p_fault_low;
    @(posedge clk_sys) disable iff (rst)
    (faultSync.openLoop || faultSync.overTemp) |=> faultOe && !faultOut;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("alert not pulled low");

  property p_fault_free;
    @(posedge clk_sys) disable iff (rst)
    !(faultSync.openLoop || faultSync.overTemp) [*2] |-> !faultOe;
  endproperty
  a_fault_free: assert property (p_fault_free) else $error("alert held after fault ended");

  c_data_load: cover property (@(posedge clk_sys) disable iff (rst) isData ##1 !clearSync);
  c_readback: cover property (@(posedge clk_sys) disable iff (rst) isRead ##[1:400] latchRise);
  c_clear: cover property (@(posedge clk_sys) disable iff (rst) clearSync ##1 !clearSync);
  c_fault: cover property (@(posedge clk_sys) disable iff (rst) $rose(faultOe));
endmodule // current_dac_serial_port
`default_nettype wire

// File: pkg/dac_port_pkg.sv
// constants and carriers for the current converter serial port
// assumes a 24-bit frame, address byte first, data word after it
package dac_port_pkg;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 16;
  localparam int CODE_BITS = 16;
  localparam int CNT_BITS = 5;
  // address byte values
  localparam logic [7:0] ADDR_NOP = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h01;
  localparam logic [7:0] ADDR_READ = 8'h02;
  localparam logic [7:0] ADDR_CTRL = 8'h03;
  // control word fields
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_DAISY_BIT = 3;
  // readback selector values (low two data bits of a read command)
  localparam logic [1:0] SEL_STATUS = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_CTRL = 2'h2;
  // output range encodings
  localparam logic [1:0] RANGE_4_20 = 2'h0;
  localparam logic [1:0] RANGE_0_20 = 2'h1;
  localparam logic [1:0] RANGE_0_24 = 2'h2;
  // values after reset
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ZERO_SCALE_CODE = 16'h0000;
  localparam logic [4:0] CNT_RESET = 5'h00;
  // timing: host clock ceiling and control settle hold
  localparam int SCLK_MAX_MHZ = 30;
  localparam int SYS_CLK_MHZ = 200;
  localparam int CTRL_HOLD_US = 5;
  localparam int CTRL_HOLD_CYC = CTRL_HOLD_US * SYS_CLK_MHZ;

  typedef enum {OUT_OFF, OUT_READ, OUT_DAISY} out_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } link_word_s;

  typedef struct packed {
    logic openLoop;
    logic overTemp;
  } fault_s;
endpackage

// File: logic/bit_sync.sv
// two-flop level synchroniser for one bit
// assumes the destination clock runs whenever the level matters
`timescale 1ns/10ps
`default_nettype none
module bit_sync (
  input wire logic clk, // destination clock
  input wire logic rst, // synchronous reset, active high
  input wire logic din, // asynchronous level
  output logic dout // synchronised level
);
  logic stage1;

  // first stage feeds the second only, never any other logic
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // bit_sync
`default_nettype wire

// File: test/host_model.sv
// host model: drives serial clock, data and load strobe
// assumes the bench calls shift, then latch, one frame at a time
`timescale 1ns/10ps
`default_nettype none
module host_model (
  output logic sclk, // serial clock, still between frames
  output logic serial_in, // serial data to device
  output logic latchPin, // load strobe
  input wire logic serial_out // serial data from device
);
  initial begin
    sclk = 1'b0;
    latchPin = 1'b0;
  end
  // bare clock pulses, so the device side sees reset
  task automatic pulses(input int n);
    repeat (n) begin
      serial_in = 1'($urandom); // junk bits, discarded by the link reset
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
  endtask
  // 24 bits msb first, device output sampled at each rise
  task automatic shift(input logic [23:0] w, output logic [23:0] got);
    for (int i = 23; i >= 0; i--) begin
      serial_in = w[i];
      // sample just before the rise, so the count update cannot race it
      #6 got[i] = serial_out;
      sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    serial_in = ~w[0]; // no stale bit left on the line
  endtask
  // strobe high for holdNs, then a quiet gap before the next frame
  task automatic latch(input int holdNs);
    #20 latchPin = 1'b1;
    #(holdNs) latchPin = 1'b0;
    #50;
  endtask
endmodule // host_model

// File: test/current_dac_serial_port_test.sv
// self-checking bench for the current converter serial port
// assumes host_model and the design are compiled before it
`timescale 1ns/10ps
`default_nettype none
module current_dac_serial_port_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clearPin;
  logic openLoopPin;
  logic overTempPin;
  wire sclk, serial_in, latchPin, serial_out, serialOutEn, faultOut, faultOe;
  wire [15:0] current_output;
  wire [1:0] outRange;
  wire [20:0] obs = {faultOut, faultOe, serialOutEn, outRange, current_output};
  int num_errors = 0;
  int n_compared = 0;
  logic [20:0] q[$];
  logic [20:0] prevObs = '0;
  logic [15:0] code = '0;
  logic [15:0] next;
  logic [1:0] rng = '0;
  logic en = 1'b0;
  logic oe = 1'b0;
  logic clr = 1'b0;
  logic [23:0] got;
  logic [2:0] pinSeq [6] = '{3'h4, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0};

  always #2.5 clk_sys = ~clk_sys;

  current_dac_serial_port dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
    .serial_in(serial_in), .latchPin(latchPin), .clearPin(clearPin),
    .openLoopPin(openLoopPin), .overTempPin(overTempPin), .serial_out(serial_out),
    .serialOutEn(serialOutEn), .faultOut(faultOut), .faultOe(faultOe),
    .current_output(current_output), .outRange(outRange));
  host_model host (.sclk(sclk), .serial_in(serial_in), .latchPin(latchPin),
    .serial_out(serial_out));

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // note the pin state the next change must produce
  task automatic expect_out();
    q.push_back({1'b0, oe, en, rng, clr ? 16'h0000 : code});
  endtask
  // bounded wait, then every note must have been taken
  task automatic settle();
    repeat (40) @(posedge clk_sys);
    check("notes left", 24'(q.size()), 24'h000000);
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // each pin change takes the oldest note; a change with none is wrong;
  // looked at on the falling edge, once the launching edge has settled
  always @(negedge clk_sys) begin
    if (!rst && obs !== prevObs) begin
      if (q.size() == 0) check("unexpected change", 24'(obs), 24'(prevObs));
      else check("pins", 24'(obs), 24'(q.pop_front()));
    end
    prevObs <= obs;
  end

  // cuts a hang short, about three times the expected run
  initial begin
    #100000;
    num_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'hAB8D));
    {clearPin, openLoopPin, overTempPin} <= 3'h0;
    host.pulses(5); // device side needs serial clock edges in reset
    @(posedge clk_sys) rst <= 1'b0;
    // link reset lingers two serial edges after release; spend them here
    // so the first frame starts with the bit count at zero
    #1 host.pulses(2);
    repeat (4) @(posedge clk_sys);
    // every range, each unlike the last, with the long control hold
    for (int r = 2; r >= 0; r--) begin
      rng = 2'(r);
      host.shift({dac_port_pkg::ADDR_CTRL, 14'h0000, rng}, got);
      expect_out();
      host.latch(5000);
      settle();
    end
    // random codes; the note is queued only after the shift
    repeat (3) begin
      next = 16'($urandom) | 16'h8000;
      if (next == code) next ^= 16'h0001;
      code = next;
      host.shift({dac_port_pkg::ADDR_DATA, code}, got);
      expect_out();
      host.latch(60);
      settle();
    end
    // no-op address changes nothing
    host.shift({dac_port_pkg::ADDR_NOP, 16'hFFFF}, got);
    host.latch(60);
    settle();
    // readback of the data register, released by the next strobe
    en = 1'b1;
    host.shift({dac_port_pkg::ADDR_READ, 14'h0000, dac_port_pkg::SEL_DATA}, got);
    expect_out();
    host.latch(60);
    settle();
    en = 1'b0;
    host.shift(24'h000000, got);
    expect_out();
    host.latch(60);
    settle();
    check("readback word", got, {dac_port_pkg::ADDR_READ, code});
    // daisy chain: the previous frame comes back out
    en = 1'b1;
    host.shift({dac_port_pkg::ADDR_CTRL, 16'h0008}, got);
    expect_out();
    host.latch(5000);
    settle();
    host.shift(24'h00A5C3, got);
    host.latch(60);
    settle();
    host.shift(24'h005A3C, got);
    check("daisy word", got, 24'h00A5C3);
    host.latch(60);
    settle();
    en = 1'b0;
    host.shift({dac_port_pkg::ADDR_CTRL, 16'h0000}, got);
    expect_out();
    host.latch(5000);
    settle();
    // clear, then each fault level on and off
    foreach (pinSeq[i]) begin
      clr = pinSeq[i][2];
      oe = |pinSeq[i][1:0];
      expect_out();
      @(posedge clk_sys) {clearPin, openLoopPin, overTempPin} <= pinSeq[i];
      settle();
    end
    test_done();
  end
endmodule // current_dac_serial_port_test
`default_nettype wire
